// *** src/slfc_check.sv ***
// Store-to-load forwarding decision for the load pipeline
`timescale 1ns/1ps
module slfc_check (
  input wire logic clk_sys,
  input wire logic rst,
  // Load request from the load pipeline, one-cycle pulse
  input wire logic ld_req,
  input wire logic [slfc_pkg::ADDR_W-1:0] ld_addr,
  input wire logic [slfc_pkg::SIZE_W-1:0] ld_size,
  // Second stage load store buffer contents, youngest has highest age
  input wire logic [slfc_pkg::SB_DEPTH-1:0] sb_valid,
  input wire logic [slfc_pkg::SB_DEPTH*slfc_pkg::ADDR_W-1:0] sb_addr,
  input wire logic [slfc_pkg::SB_DEPTH*slfc_pkg::SIZE_W-1:0] sb_size,
  input wire logic [slfc_pkg::SB_DEPTH*slfc_pkg::DATA_W-1:0] sb_data,
  input wire logic [slfc_pkg::SB_DEPTH-1:0] sb_hibyte,
  input wire logic [slfc_pkg::SB_DEPTH*slfc_pkg::ROB_TAG_W-1:0] sb_rob_tag,
  // Index of the youngest entry; entries are in ring order from head
  input wire logic [slfc_pkg::SB_IDX_W-1:0] sb_head,
  // Reorder buffer: tag of the oldest instruction not yet retired
  input wire logic rob_empty,
  input wire logic [slfc_pkg::ROB_TAG_W-1:0] rob_oldest_tag,
  // Data cache write acknowledge for the oldest store
  input wire logic dc_wr_done,
  // Results
  output logic ld_fwd_valid,
  output logic [slfc_pkg::DATA_W-1:0] ld_fwd_data,
  output logic ld_go_cache,
  output logic ld_stall,
  output logic sb_retire
);
  typedef struct packed {
    slfc_pkg::slfc_state_t st;
    logic [slfc_pkg::SB_IDX_W-1:0] wait_idx;
    logic fwd_valid;
    logic [slfc_pkg::DATA_W-1:0] fwd_data;
    logic go_cache;
    logic stall;
    logic retire;
  } slfc_regs_t;

  slfc_regs_t r_q;
  slfc_regs_t r_d;

  // ----------------------------------------------------------------
  // Per-entry alignment and byte ranges
  // ----------------------------------------------------------------
  logic [slfc_pkg::SB_DEPTH-1:0] st_aligned;
  logic [slfc_pkg::SB_DEPTH*slfc_pkg::ADDR_W-1:0] st_last;
  logic ld_aligned;
  logic [slfc_pkg::ADDR_W-1:0] ld_last;

  slfc_align u_ld_align (
    .addr(ld_addr),
    .size(ld_size),
    .aligned(ld_aligned),
    .last_addr(ld_last)
  );

  for (genvar g = 0; g < slfc_pkg::SB_DEPTH; g++) begin : g_st
    slfc_align u_st_align (
      .addr(sb_addr[g*slfc_pkg::ADDR_W +: slfc_pkg::ADDR_W]),
      .size(sb_size[g*slfc_pkg::SIZE_W +: slfc_pkg::SIZE_W]),
      .aligned(st_aligned[g]),
      .last_addr(st_last[g*slfc_pkg::ADDR_W +: slfc_pkg::ADDR_W])
    );
  end

  // ----------------------------------------------------------------
  // Youngest partial-address match
  // ----------------------------------------------------------------
  logic hit;
  logic [slfc_pkg::SB_IDX_W-1:0] hit_idx;
  logic [slfc_pkg::SB_IDX_W-1:0] scan_idx;

  // Walk from oldest to youngest so the last match wins
  always_comb begin
    hit = 1'b0;
    hit_idx = slfc_pkg::IDX_RST;
    scan_idx = slfc_pkg::IDX_RST;
    for (int i = slfc_pkg::SB_DEPTH - 1; i >= 0; i--) begin
      scan_idx = sb_head - slfc_pkg::SB_IDX_W'(i);
      // Upper page bits ignored, so page aliases match too
      if (sb_valid[scan_idx] && (sb_addr[scan_idx*slfc_pkg::ADDR_W + slfc_pkg::CMP_LO +: 10] ==
          ld_addr[slfc_pkg::CMP_HI:slfc_pkg::CMP_LO])) begin
        hit = 1'b1;
        hit_idx = scan_idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // Forwarding conditions against the chosen entry
  // ----------------------------------------------------------------
  logic [slfc_pkg::ADDR_W-1:0] h_addr;
  logic [slfc_pkg::ADDR_W-1:0] h_last;
  logic [slfc_pkg::SIZE_W-1:0] h_size;
  logic same_start;
  logic size_ok;
  logic both_aligned;
  logic narrow_partial;
  logic wide_offset;
  logic can_fwd;

  always_comb begin
    h_addr = sb_addr[hit_idx*slfc_pkg::ADDR_W +: slfc_pkg::ADDR_W];
    h_last = st_last[hit_idx*slfc_pkg::ADDR_W +: slfc_pkg::ADDR_W];
    h_size = sb_size[hit_idx*slfc_pkg::SIZE_W +: slfc_pkg::SIZE_W];
    same_start = (h_addr == ld_addr);
    size_ok = (ld_size <= h_size);
    both_aligned = ld_aligned && st_aligned[hit_idx];
    // Narrow store touching part of a wider load
    narrow_partial = (h_size < ld_size) && (h_addr <= ld_last) && (h_last >= ld_addr);
    wide_offset = (h_size > ld_size) && !same_start;
    can_fwd = same_start && size_ok && both_aligned && !sb_hibyte[hit_idx]
              && !narrow_partial && !wide_offset;
  end

  // ----------------------------------------------------------------
  // Retirement of the oldest store entry
  // ----------------------------------------------------------------
  logic [slfc_pkg::SB_IDX_W-1:0] tail_idx;
  logic [slfc_pkg::SB_IDX_W-1:0] old_scan;
  logic old_found;
  logic head_may_retire;

  // Oldest live entry is the first valid one after the youngest in ring order;
  // a partly filled ring leaves gaps, so the slot after the head is not enough
  always_comb begin
    tail_idx = slfc_pkg::IDX_RST;
    old_scan = slfc_pkg::IDX_RST;
    old_found = 1'b0;
    for (int i = 1; i <= slfc_pkg::SB_DEPTH; i++) begin
      old_scan = sb_head + slfc_pkg::SB_IDX_W'(i);
      if (!old_found && sb_valid[old_scan]) begin
        old_found = 1'b1;
        tail_idx = old_scan;
      end
    end
    // The store's own tag must be the oldest left, or the ROB empty; nothing older remains
    head_may_retire = old_found &&
                      (rob_empty || (rob_oldest_tag == sb_rob_tag[tail_idx*slfc_pkg::ROB_TAG_W +:
                      slfc_pkg::ROB_TAG_W]));
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.fwd_valid = 1'b0;
    r_d.go_cache = 1'b0;
    r_d.retire = head_may_retire && !r_q.retire;
    unique case (r_q.st)
      slfc_pkg::SLFC_IDLE: begin
        if (ld_req) begin
          if (!hit) begin
            r_d.go_cache = 1'b1;
          end else if (can_fwd) begin
            r_d.fwd_valid = 1'b1;
            r_d.fwd_data = sb_data[hit_idx*slfc_pkg::DATA_W +: slfc_pkg::DATA_W];
          end else begin
            r_d.st = slfc_pkg::SLFC_WAIT;
            r_d.wait_idx = hit_idx;
            r_d.stall = 1'b1;
          end
        end
      end
      slfc_pkg::SLFC_WAIT: begin
        // Entry gone and cache written: load may now read the cache
        if (dc_wr_done && !sb_valid[r_q.wait_idx]) begin
          r_d.st = slfc_pkg::SLFC_DONE;
        end
      end
      slfc_pkg::SLFC_DONE: begin
        r_d.st = slfc_pkg::SLFC_IDLE;
        r_d.stall = 1'b0;
        r_d.go_cache = 1'b1;
      end
      // Illegal one-hot code falls back to idle
      default: begin
        r_d.st = slfc_pkg::SLFC_IDLE;
        r_d.stall = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_q.st <= slfc_pkg::SLFC_IDLE;
      r_q.wait_idx <= slfc_pkg::IDX_RST;
      r_q.fwd_valid <= 1'b0;
      r_q.fwd_data <= slfc_pkg::DATA_RST;
      r_q.go_cache <= 1'b0;
      r_q.stall <= 1'b0;
      r_q.retire <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign ld_fwd_valid = r_q.fwd_valid;
  assign ld_fwd_data = r_q.fwd_data;
  assign ld_go_cache = r_q.go_cache;
  assign ld_stall = r_q.stall;
  assign sb_retire = r_q.retire;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fwd_needs_match: assert property (@(posedge clk_sys) disable iff (rst)
    ld_req && !r_q.stall && hit && !same_start |=> !ld_fwd_valid)
    else $error("forward without start match");
  a_fwd_size_ok: assert property (@(posedge clk_sys) disable iff (rst)
    ld_req && !r_q.stall && hit && (ld_size > h_size) |=> !ld_fwd_valid)
    else $error("forward to wider load");
  a_fwd_misalign: assert property (@(posedge clk_sys) disable iff (rst)
    ld_req && !r_q.stall && hit && !both_aligned |=> !ld_fwd_valid && ld_stall)
    else $error("misaligned access forwarded");
  a_fwd_hibyte: assert property (@(posedge clk_sys) disable iff (rst)
    ld_req && !r_q.stall && hit && sb_hibyte[hit_idx] |=> ld_stall)
    else $error("high-byte store forwarded");
  a_wait_release: assert property (@(posedge clk_sys) disable iff (rst)
    ld_stall && !(dc_wr_done && !sb_valid[r_q.wait_idx]) && r_q.st == slfc_pkg::SLFC_WAIT
    |=> ld_stall && !ld_go_cache)
    else $error("stalled load released early");
  a_retire_order: assert property (@(posedge clk_sys) disable iff (rst)
    sb_retire |-> $past(head_may_retire))
    else $error("store retired past older work");
  a_fwd_data_ok: assert property (@(posedge clk_sys) disable iff (rst)
    ld_req && !r_q.stall && hit && can_fwd
    |=> ld_fwd_valid && ld_fwd_data == $past(sb_data[hit_idx*slfc_pkg::DATA_W +: slfc_pkg::DATA_W]))
    else $error("forward data missing");
  a_qword_dword: assert property (@(posedge clk_sys) disable iff (rst)
    ld_req && !r_q.stall && hit && same_start && both_aligned && !sb_hibyte[hit_idx]
    && h_size == slfc_pkg::SZ_QWORD && ld_size == slfc_pkg::SZ_DWORD |=> ld_fwd_valid)
    else $error("qword to dword case refused");
  a_nohit_cache: assert property (@(posedge clk_sys) disable iff (rst)
    ld_req && !r_q.stall && !hit |=> ld_go_cache && !ld_fwd_valid && !ld_stall)
    else $error("unmatched load not sent to cache");
endmodule : slfc_check

// *** pkg/slfc_pkg.sv ***
// Constants and types shared by the store-to-load forwarding check
package slfc_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 48;
  localparam int DATA_W = 64;
  localparam int SIZE_W = 2;
  localparam int SB_DEPTH = 8;
  localparam int SB_IDX_W = 3;
  localparam int ROB_TAG_W = 6;
  // Partial address compare window, bits 11 down to 2
  localparam int CMP_HI = 11;
  localparam int CMP_LO = 2;
  // ----------------------------------------------------------------
  // Operand size codes (log2 of bytes)
  // ----------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  localparam logic [1:0] SZ_QWORD = 2'h3;
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 64'h0000_0000_0000_0000;
  localparam logic [SB_IDX_W-1:0] IDX_RST = 3'h0;
  // ----------------------------------------------------------------
  // Load decision states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SLFC_IDLE = 3'b001,
    SLFC_WAIT = 3'b010,
    SLFC_DONE = 3'b100
  } slfc_state_t;
endpackage : slfc_pkg

// *** src/slfc_align.sv ***
// Natural alignment and byte-range helper for one access
`timescale 1ns/1ps
module slfc_align (
  input wire logic [slfc_pkg::ADDR_W-1:0] addr,
  input wire logic [slfc_pkg::SIZE_W-1:0] size,
  output logic aligned,
  output logic [slfc_pkg::ADDR_W-1:0] last_addr
);
  logic [3:0] low_mask;

  // Low address bits that must be zero for the operand size
  always_comb begin
    unique case (size)
      slfc_pkg::SZ_BYTE: low_mask = 4'h0;
      slfc_pkg::SZ_WORD: low_mask = 4'h1;
      slfc_pkg::SZ_DWORD: low_mask = 4'h3;
      slfc_pkg::SZ_QWORD: low_mask = 4'h7;
    endcase
    aligned = ((addr[2:0] & low_mask[2:0]) == 3'h0);
    last_addr = addr + {{(slfc_pkg::ADDR_W-4){1'b0}}, low_mask};
  end
endmodule : slfc_align

// *** testbench/slfc_far_model.sv ***
// Far-side model: store buffer ring and data cache write port
`timescale 1ns/1ps
module slfc_far_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sb_retire,
  output logic [7:0] sb_valid,
  output logic [383:0] sb_addr,
  output logic [15:0] sb_size,
  output logic [511:0] sb_data,
  output logic [7:0] sb_hibyte,
  output logic [47:0] sb_rob_tag,
  output logic [2:0] sb_head,
  output logic dc_wr_done
);
  logic [47:0] a[8];
  logic [1:0] s[8];
  logic [63:0] d[8];
  logic [2:0] j;
  // ----------------------------------------------------------------
  // Retire and cache write
  // ----------------------------------------------------------------
  // Retired entries show inverted address and data, so stale values never pass for live
  always @(posedge clk_sys) begin
    dc_wr_done <= 1'b0;
    if (rst) begin
      sb_valid <= 8'h00;
    end else if (sb_retire) begin
      j = sb_head + 3'h1;
      while (!sb_valid[j] && j != sb_head) j = j + 3'h1;
      sb_valid[j] <= 1'b0;
      a[j] <= ~a[j];
      d[j] <= ~d[j];
      dc_wr_done <= 1'b1;
    end
  end
  // Pack the ring onto the flat ports
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sb_addr[i*48+:48] = a[i];
      sb_size[i*2+:2] = s[i];
      sb_data[i*64+:64] = d[i];
    end
  end
  // Bench hooks; all live entries carry their slot as ROB tag
  task automatic put(input int i, input logic [47:0] ad, input logic [1:0] sz, input logic [63:0] dt,
                     input logic hb);
    a[i] = ad;
    s[i] = sz;
    d[i] = dt;
    sb_hibyte[i] = hb;
    sb_rob_tag[i*6+:6] = 6'(i);
    sb_valid[i] = 1'b1;
  endtask : put
  task automatic clear(input logic [2:0] hd);
    sb_valid = 8'h00;
    sb_head = hd;
    for (int i = 0; i < 8; i++) begin
      a[i] = 48'h0000_0000_0000;
      s[i] = 2'h0;
      d[i] = 64'h0000_0000_0000_0000;
    end
  endtask : clear
  initial begin
    sb_hibyte = 8'h00;
    sb_rob_tag = 48'h0000_0000_0000;
    dc_wr_done = 1'b0;
    clear(3'h0);
  end
endmodule : slfc_far_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the forwarding decision block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, ld_req = 1'b0, rob_empty = 1'b0;
  logic [47:0] ld_addr = 48'h0000_0000_0000;
  logic [1:0] ld_size = 2'h0;
  logic [5:0] rob_oldest_tag = 6'h3f;
  logic [7:0] sb_valid, sb_hibyte;
  logic [383:0] sb_addr;
  logic [15:0] sb_size;
  logic [511:0] sb_data;
  logic [47:0] sb_rob_tag;
  logic [2:0] sb_head, hd;
  logic dc_wr_done, ld_fwd_valid, ld_go_cache, ld_stall, sb_retire;
  logic [63:0] ld_fwd_data, ed;
  logic [47:0] ma[8];
  logic [1:0] ms[8];
  logic [63:0] md[8];
  logic mh[8], mv[8];
  int mismatches = 0, n_tests = 0, tno = 0;
  always #5 clk_sys = ~clk_sys;
  slfc_check u_slfc_check (.clk_sys(clk_sys), .rst(rst), .ld_req(ld_req), .ld_addr(ld_addr), .ld_size(ld_size),
    .sb_valid(sb_valid), .sb_addr(sb_addr), .sb_size(sb_size), .sb_data(sb_data), .sb_hibyte(sb_hibyte),
    .sb_rob_tag(sb_rob_tag), .sb_head(sb_head), .rob_empty(rob_empty), .rob_oldest_tag(rob_oldest_tag),
    .dc_wr_done(dc_wr_done), .ld_fwd_valid(ld_fwd_valid), .ld_fwd_data(ld_fwd_data),
    .ld_go_cache(ld_go_cache), .ld_stall(ld_stall), .sb_retire(sb_retire));
  slfc_far_model u_slfc_far_model (.clk_sys(clk_sys), .rst(rst), .sb_retire(sb_retire), .sb_valid(sb_valid),
    .sb_addr(sb_addr), .sb_size(sb_size), .sb_data(sb_data), .sb_hibyte(sb_hibyte), .sb_rob_tag(sb_rob_tag),
    .sb_head(sb_head), .dc_wr_done(dc_wr_done));
  // ----------------------------------------------------------------
  // Compare, report and close
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %b", $time, what, got);
    end
  endtask : cmp_bit
  task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t data %h want %h", $time, got, exp);
    end
  endtask : cmp_data
  // Expected outcome: 0 cache read, 1 forward, 2 stall; youngest match wins
  function automatic int expect_kind(input logic [47:0] la, input logic [1:0] lz, output logic [63:0] dt);
    logic [2:0] j;
    logic [7:0] lm, sm;
    for (int k = 0; k < 8; k++) begin
      j = hd - 3'(k);
      if (mv[j] && ma[j][11:2] == la[11:2]) begin
        lm = 8'((1 << lz) - 1);
        sm = 8'((1 << ms[j]) - 1);
        dt = md[j] & ((64'h1 << (8 << lz)) - 64'h1);
        if (lz == 2'h3) dt = md[j];
        return (ma[j] == la && lz <= ms[j] && (la[7:0] & lm) == 0 && (ma[j][7:0] & sm) == 0 && !mh[j]) ? 1 : 2;
      end
    end
    dt = 64'h0;
    return 0;
  endfunction : expect_kind
  task automatic put(input int i, input logic [47:0] ad, input logic [1:0] sz, input logic hb);
    ma[i] = ad;
    ms[i] = sz;
    md[i] = {$urandom, $urandom};
    mh[i] = hb;
    mv[i] = 1'b1;
    u_slfc_far_model.put(i, ad, sz, md[i], hb);
  endtask : put
  task automatic fresh(input logic [2:0] h);
    hd = h;
    for (int i = 0; i < 8; i++) mv[i] = 1'b0;
    u_slfc_far_model.clear(h);
  endtask : fresh
  // One load; a refused load is held with the ROB blocked, then released
  task automatic do_load(input logic [47:0] la, input logic [1:0] lz);
    int k, n;
    k = expect_kind(la, lz, ed);
    @(posedge clk_sys) ld_req <= 1'b1;
    ld_addr <= la;
    ld_size <= lz;
    @(posedge clk_sys) ld_req <= 1'b0;
    // Look after the launching edge has settled the one-cycle answer
    #1;
    for (n = 0; n < 4 && !(ld_fwd_valid | ld_go_cache | ld_stall); n++) @(posedge clk_sys) #1;
    if (n == 4) begin
      mismatches++;
      $display("BAD t=%0t no answer to load", $time);
      conclude();
    end
    cmp_bit(ld_fwd_valid, k == 1, "fwd");
    cmp_bit(ld_go_cache, k == 0, "cache");
    cmp_bit(ld_stall, k == 2, "stall");
    if (k == 1) cmp_data(ld_fwd_data & ((lz == 2'h3) ? '1 : ((64'h1 << (8 << lz)) - 64'h1)), ed);
    if (k == 2) begin
      for (n = 0; n < 20; n++) begin
        @(posedge clk_sys) ld_req <= (n == 2);
        #1 cmp_bit(sb_retire | ld_fwd_valid | ~ld_stall, 1'b0, "hold");
      end
      @(posedge clk_sys) rob_empty <= 1'b1;
      for (n = 0; n < 100 && !ld_go_cache; n++) @(posedge clk_sys) #1;
      if (n == 100) begin
        mismatches++;
        $display("BAD t=%0t stalled load never released", $time);
        conclude();
      end
      cmp_bit(ld_stall, 1'b0, "release");
      @(posedge clk_sys) rob_empty <= 1'b0;
      // Let a late retire pulse drain before the ring is reloaded
      repeat (3) @(posedge clk_sys) #1;
    end
    $display("test %0d done kind %0d", ++tno, k);
  endtask : do_load
  task automatic corner(input logic [47:0] sa, input logic [1:0] sz, input logic hb, input logic [47:0] la,
                        input logic [1:0] lz, input logic older);
    fresh(3'h5);
    if (older) put(4, {la[47:3], 3'h0}, 2'h3, 1'b0);
    put(5, sa, sz, hb);
    do_load(la, lz);
  endtask : corner
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(37));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Far model still clears its ring on this edge; load it only after
    @(posedge clk_sys) #1;
    corner(48'h0100, 2'h3, 1'b0, 48'h0100, 2'h2, 1'b0);
    corner(48'h0100, 2'h2, 1'b0, 48'h0100, 2'h2, 1'b0);
    corner(48'h0104, 2'h3, 1'b0, 48'h0104, 2'h3, 1'b0);
    corner(48'h0101, 2'h1, 1'b0, 48'h0101, 2'h1, 1'b0);
    corner(48'h0100, 2'h1, 1'b0, 48'h0100, 2'h2, 1'b0);
    corner(48'h0100, 2'h2, 1'b0, 48'h0102, 2'h1, 1'b0);
    corner(48'h0100, 2'h0, 1'b1, 48'h0100, 2'h0, 1'b0);
    corner(48'h1100, 2'h2, 1'b0, 48'h0100, 2'h2, 1'b0);
    corner(48'h0200, 2'h2, 1'b0, 48'h0100, 2'h2, 1'b0);
    corner(48'h0100, 2'h1, 1'b0, 48'h0100, 2'h1, 1'b1);
    corner(48'h0100, 2'h0, 1'b1, 48'h0100, 2'h0, 1'b1);
    for (int t = 0; t < 40; t++) begin
      fresh(3'($urandom));
      for (int e = 0; e <= $urandom % 8; e++)
        put(3'(hd - 3'(e)), 48'h0100 + 48'($urandom % 16) + ($urandom % 4 == 0 ? 48'h1000 : 48'h0), 2'($urandom),
            $urandom % 4 == 0);
      do_load(48'h0100 + 48'($urandom % 16), 2'($urandom));
    end
    conclude();
  end
endmodule : tb_top
